// ==== include/irq_cfg.svh ====
`ifndef IRQ_CFG_SVH
`define IRQ_CFG_SVH
// Notes on behaviour
// - Bits 3:2 pick falling, rising, both; 10 barred
// - Reset clears edge mode register to zero
// - Enable bit gates maskable acknowledgment; byte, bit, instructions
// - Status word resets to 02h, interrupts disabled
// - Acknowledge saves status, clears enable, vectors
// - Key enable bit arms falling-edge key detection
// - Reset clears key mode register, detection off
// - Key detection also follows pins driven out
// - Key event only while all pins were high
// - Non-maskable ignores enable, beats all maskables
// - Non-maskable nests into its own service
// - Maskable needs flag set, unmasked, enabled
// - Maskable service starts 9 to 19 clocks later
// - Simultaneous maskables served singly by priority
// - Blocked requests stay pending until acceptable
// - Flag by clock n-1 taken after instruction
// - Flag or mask register access holds requests
// - Maskable nesting only after routine re-enables interrupts
// - Priority 0 highest down to 7 lowest
// - Acknowledge clears the source request flag

// Register addresses on the internal data bus
`define ADDR_REQ_FLAGS 16'hffe0
`define ADDR_MASK_FLAGS 16'hffe4
`define ADDR_EDGE_MODE 16'hffec
`define ADDR_KEY_MODE 16'hfff5

// Reset values
`define RST_EDGE_MODE 8'h00
`define RST_KEY_MODE 8'h00
`define RST_STATUS_WORD 8'h02
`define RST_REQ_FLAGS 8'h00
`define RST_MASK_FLAGS 8'hff

// Writable bits of the mode registers; the rest read as zero
`define EDGE_MODE_WMASK 8'h0c
`define KEY_MODE_WMASK 8'h01

// Field positions
`define EDGE_SEL_HI_BIT 3
`define EDGE_SEL_LO_BIT 2
`define KEY_DETECT_BIT 0
`define IRQ_ENABLE_BIT 7

// Source slots in the request and mask flag registers
`define SRC_EXT_PIN 1
`define SRC_KEY_RETURN 6

// Vector table
`define VEC_NONMASK 16'h0004
`define VEC_MASK_BASE 16'h0004

// Maskable latency window in CPU clocks
`define LAT_MIN_CLK 9
`define LAT_MAX_CLK 19
`endif

// ==== include/irq_pkg.sv ====
package irq_pkg;
	// Edge selection codes for the external pin, barred code included
	typedef enum logic [1:0] {
		EDGE_FALL = 2'b00,
		EDGE_RISE = 2'b01,
		EDGE_BARRED = 2'b10,
		EDGE_BOTH = 2'b11
	} edge_sel_type;

	// Kind of acknowledge presented to the CPU core
	typedef enum logic [1:0] {
		ACK_NONE = 2'b00,
		ACK_NONMASK = 2'b01,
		ACK_MASKABLE = 2'b10
	} ack_kind_type;

	// State of the controller, except the key detector's all-high flag
	typedef struct packed {
		logic [7:0] edge_mode;
		logic [7:0] key_mode;
		logic [7:0] status_word;
		logic [7:0] req;
		logic [7:0] mask;
		logic nonmask_pend;
		logic ext_prev;
		logic hold_acc;
		ack_kind_type ack_kind;
		logic [15:0] vector;
		logic [7:0] saved_status;
		logic [7:0] rdata;
	} ctrl_state_type;

	// State of the key falling-edge detector
	typedef struct packed {
		logic all_high_prev;
	} key_state_type;
endpackage : irq_pkg

// ==== src/key_fall_detect.sv ====
`timescale 1ns/1ps
`include "irq_cfg.svh"
module key_fall_detect #(
	parameter int PINS = 4
) (
	input wire logic clk_sys_in,
	input wire logic nrst_in,
	input wire logic detect_en_in,
	input wire logic [PINS-1:0] key_pins_in,
	output logic key_fall_out
);
	import irq_pkg::*;

	key_state_type s;
	key_state_type next_s;
	logic all_high;

	// Pad levels are used whatever the pin direction
	assign all_high = &key_pins_in;

	// Remember whether every key pin was high
	always_comb
	begin
		next_s = s;
		next_s.all_high_prev = all_high;
	end

	always_ff @(posedge clk_sys_in or negedge nrst_in)
	begin
		if (!nrst_in)
			s <= '0;
		else
			s <= next_s;
	end

	// Any number of pins dropping out of an all-high set is an event
	assign key_fall_out = detect_en_in & s.all_high_prev & ~all_high;
endmodule : key_fall_detect

// ==== src/edge_select_key_return_irq_ack.sv ====
`timescale 1ns/1ps
`include "irq_cfg.svh"
module edge_select_key_return_irq_ack (
	input wire logic clk_sys_in,
	input wire logic nrst_in,
	// Data bus access to the mapped registers
	input wire logic [15:0] addr_in,
	input wire logic [7:0] wdata_in,
	input wire logic wr_in,
	input wire logic rd_in,
	output logic [7:0] rdata_out,
	// Status word access from the core
	input wire logic status_wr_in,
	input wire logic [7:0] status_wdata_in,
	input wire logic enable_irq_instr_in,
	input wire logic disable_irq_instr_in,
	input wire logic return_from_irq_instr_in,
	input wire logic [7:0] popped_status_in,
	output logic [7:0] program_status_word_out,
	// Instruction boundary and flag-register hold
	input wire logic instr_last_in,
	input wire logic flag_access_in,
	// Interrupt sources
	input wire logic [7:0] src_req_in,
	input wire logic ext_pin_irq_in,
	input wire logic [3:0] key_pins_in,
	input wire logic nonmask_req_in,
	// Acknowledge towards the core
	output logic ack_out,
	output irq_pkg::ack_kind_type ack_kind_out,
	output logic [15:0] vector_out,
	output logic [7:0] saved_status_out,
	output logic pending_out
);
	import irq_pkg::*;

	ctrl_state_type s;
	ctrl_state_type next_s;
	edge_sel_type edge_sel;
	logic irq_enable;
	logic key_fall;
	logic ext_fall;
	logic ext_rise;
	logic ext_event;
	logic [7:0] hw_set;
	logic [7:0] eligible;
	logic [2:0] win_idx;
	logic win_found;
	logic flag_acc_now;
	logic hold;
	logic boundary;
	logic take_nonmask;
	logic take_mask;

	// Key return detector on the four key pins
	key_fall_detect #(
		.PINS(4)
	) u_key (
		.clk_sys_in(clk_sys_in),
		.nrst_in(nrst_in),
		.detect_en_in(s.key_mode[`KEY_DETECT_BIT]),
		.key_pins_in(key_pins_in),
		.key_fall_out(key_fall)
	);

	// Edge selection of the external pin
	assign edge_sel = edge_sel_type'({s.edge_mode[`EDGE_SEL_HI_BIT],
		s.edge_mode[`EDGE_SEL_LO_BIT]});
	assign ext_fall = s.ext_prev & ~ext_pin_irq_in;
	assign ext_rise = ~s.ext_prev & ext_pin_irq_in;

	// Barred code detects nothing
	always_comb
	begin
		case (edge_sel)
			EDGE_FALL: ext_event = ext_fall;
			EDGE_RISE: ext_event = ext_rise;
			EDGE_BOTH: ext_event = ext_fall | ext_rise;
			default: ext_event = 1'b0;
		endcase
	end

	// Hardware set vector with pin and key slots substituted
	always_comb
	begin
		hw_set = src_req_in;
		hw_set[`SRC_EXT_PIN] = ext_event;
		hw_set[`SRC_KEY_RETURN] = key_fall;
	end

	// Flag set, unmasked and globally enabled
	assign irq_enable = s.status_word[`IRQ_ENABLE_BIT];
	assign eligible = s.req & ~s.mask & {8{irq_enable}};

	// Lowest slot number wins among simultaneous requests
	always_comb
	begin
		win_idx = 3'h0;
		win_found = 1'b0;
		for (int i = 7; i >= 0; i--)
		begin
			if (eligible[i])
			begin
				win_idx = 3'(i);
				win_found = 1'b1;
			end
		end
	end

	// Any access to the flag or mask register stalls acknowledge
	assign flag_acc_now = flag_access_in | ((wr_in | rd_in) &
		((addr_in == `ADDR_REQ_FLAGS) | (addr_in == `ADDR_MASK_FLAGS)));
	assign hold = flag_acc_now | s.hold_acc;

	// Decide only on the final clock, from flags already registered
	assign boundary = instr_last_in & ~hold & (s.ack_kind == ACK_NONE);
	// Non-maskable ignores the enable bit and wins outright
	assign take_nonmask = boundary & s.nonmask_pend;
	// Eligible maskable taken at the boundary
	assign take_mask = boundary & ~s.nonmask_pend & win_found;

	// Next-state of the whole controller
	always_comb
	begin
		next_s = s;
		next_s.ext_prev = ext_pin_irq_in;
		next_s.ack_kind = ACK_NONE;

		// Hold lasts until the accessing instruction ends
		if (instr_last_in)
			next_s.hold_acc = 1'b0;
		else if (flag_acc_now)
			next_s.hold_acc = 1'b1;

		// Mapped register writes, reserved bits kept at zero
		if (wr_in)
		begin
			case (addr_in)
				`ADDR_EDGE_MODE:
					next_s.edge_mode = wdata_in & `EDGE_MODE_WMASK;
				`ADDR_KEY_MODE:
					next_s.key_mode = wdata_in & `KEY_MODE_WMASK;
				`ADDR_REQ_FLAGS: next_s.req = wdata_in;
				`ADDR_MASK_FLAGS: next_s.mask = wdata_in;
				default: next_s.mask = next_s.mask;
			endcase
		end

		// Acknowledge clears the winning flag first
		if (take_mask)
			next_s.req[win_idx] = 1'b0;
		// Hardware set wins over any clear; unserved flags stay
		next_s.req = next_s.req | hw_set;

		// Non-maskable pending latch, a new pulse wins over the take
		if (take_nonmask)
			next_s.nonmask_pend = 1'b0;
		if (nonmask_req_in)
			next_s.nonmask_pend = 1'b1;

		// Status word: return, byte write, then the enable instructions
		if (return_from_irq_instr_in)
			next_s.status_word = popped_status_in;
		else if (status_wr_in)
			next_s.status_word = status_wdata_in;
		if (enable_irq_instr_in)
			next_s.status_word[`IRQ_ENABLE_BIT] = 1'b1;
		if (disable_irq_instr_in)
			next_s.status_word[`IRQ_ENABLE_BIT] = 1'b0;

		// Acknowledge: save status, clear enable, load vector
		if (take_nonmask | take_mask)
		begin
			next_s.saved_status = s.status_word;
			next_s.status_word[`IRQ_ENABLE_BIT] = 1'b0;
			if (take_nonmask)
			begin
				next_s.ack_kind = ACK_NONMASK;
				next_s.vector = `VEC_NONMASK;
			end
			else
			begin
				next_s.ack_kind = ACK_MASKABLE;
				next_s.vector = `VEC_MASK_BASE +
					{12'h000, win_idx, 1'b0};
			end
		end

		// Registered read data; unmapped addresses read zero
		if (rd_in)
		begin
			case (addr_in)
				`ADDR_EDGE_MODE: next_s.rdata = s.edge_mode;
				`ADDR_KEY_MODE: next_s.rdata = s.key_mode;
				`ADDR_REQ_FLAGS: next_s.rdata = s.req;
				`ADDR_MASK_FLAGS: next_s.rdata = s.mask;
				default: next_s.rdata = 8'h00;
			endcase
		end
	end

	// State register with documented reset values
	always_ff @(posedge clk_sys_in or negedge nrst_in)
	begin
		if (!nrst_in)
		begin
			s <= '0;
			s.edge_mode <= `RST_EDGE_MODE;
			s.key_mode <= `RST_KEY_MODE;
			s.status_word <= `RST_STATUS_WORD;
			s.req <= `RST_REQ_FLAGS;
			s.mask <= `RST_MASK_FLAGS;
			s.ack_kind <= ACK_NONE;
		end
		else
			s <= next_s;
	end

	// Outputs
	assign rdata_out = s.rdata;
	assign program_status_word_out = s.status_word;
	assign ack_out = (s.ack_kind != ACK_NONE);
	assign ack_kind_out = s.ack_kind;
	assign vector_out = s.vector;
	assign saved_status_out = s.saved_status;
	assign pending_out = s.nonmask_pend | (|(s.req & ~s.mask));

	// Checks
	default clocking cb @(posedge clk_sys_in);
	endclocking
	default disable iff (!nrst_in);

	sequence seq_boundary_nonmask;
		instr_last_in && !hold && s.ack_kind == ACK_NONE && s.nonmask_pend;
	endsequence

	sequence seq_boundary_mask;
		instr_last_in && !hold && s.ack_kind == ACK_NONE &&
			!s.nonmask_pend && |eligible;
	endsequence

	chk_edge_reserved: assert property (
		(s.edge_mode & ~`EDGE_MODE_WMASK) == 8'h00)
		else $error("edge mode reserved bits set");

	chk_edge_falling: assert property (
		edge_sel == EDGE_FALL && s.ext_prev && !ext_pin_irq_in
		|=> s.req[`SRC_EXT_PIN])
		else $error("falling edge not flagged");

	chk_edge_barred: assert property (
		edge_sel == EDGE_BARRED |-> !hw_set[`SRC_EXT_PIN])
		else $error("barred edge code detected an edge");

	chk_key_detect: assert property (
		s.key_mode[`KEY_DETECT_BIT] && $past(&key_pins_in) &&
		!(&key_pins_in) |=> s.req[`SRC_KEY_RETURN])
		else $error("key falling edge not flagged");

	chk_key_all_high: assert property (
		key_fall |-> $past(&key_pins_in) && s.key_mode[`KEY_DETECT_BIT])
		else $error("key event without all pins high");

	chk_nonmask_wins: assert property (
		seq_boundary_nonmask |=> s.ack_kind == ACK_NONMASK &&
		vector_out == `VEC_NONMASK)
		else $error("non-maskable not taken first");

	chk_mask_taken: assert property (
		seq_boundary_mask |=> s.ack_kind == ACK_MASKABLE)
		else $error("eligible maskable not taken at boundary");

	chk_mask_cond: assert property (
		s.ack_kind == ACK_MASKABLE |-> $past(irq_enable) &&
		$past(|(s.req & ~s.mask)))
		else $error("maskable taken without its conditions");

	chk_priority_vec: assert property (
		seq_boundary_mask |=> vector_out == `VEC_MASK_BASE +
		{12'h000, $past(win_idx), 1'b0})
		else $error("wrong priority winner");

	chk_ack_saves: assert property (
		ack_out |-> !s.status_word[`IRQ_ENABLE_BIT] &&
		saved_status_out == $past(s.status_word) ##1 !ack_out)
		else $error("acknowledge did not save status");

	chk_hold_access: assert property (
		flag_acc_now && instr_last_in |=> !ack_out)
		else $error("acknowledge during flag access");

	chk_final_clock: assert property (
		instr_last_in && !(|eligible) && !s.nonmask_pend |=> !ack_out)
		else $error("flag from final clock taken early");

	chk_pending_kept: assert property (
		!take_mask && !wr_in |=> (s.req & $past(s.req)) == $past(s.req))
		else $error("pending request lost");

	chk_flag_cleared: assert property (
		take_mask && !hw_set[win_idx] && !wr_in
		|=> !s.req[$past(win_idx)])
		else $error("served flag not cleared");

	chk_return_restore: assert property (
		return_from_irq_instr_in && !enable_irq_instr_in &&
		!disable_irq_instr_in && !boundary |=>
		s.status_word == $past(popped_status_in))
		else $error("status word not restored");

	chk_enable_instr: assert property (
		enable_irq_instr_in && !disable_irq_instr_in && !boundary
		|=> irq_enable)
		else $error("enable instruction ignored");
endmodule : edge_select_key_return_irq_ack

// ==== bench/cpu_core_model.sv ====
`timescale 1ns/1ps
module cpu_core_model (
	input wire logic clk_sys_in,
	input wire logic nrst_in,
	input wire logic ack_in,
	input wire logic [7:0] saved_status_in,
	input wire logic ret_req_in,
	output logic instr_last_out,
	output logic return_from_irq_instr_out,
	output logic [7:0] popped_out
);
	logic [1:0] cnt;
	logic [7:0] stack [$];
	// Four-clock instructions, final clock flagged; stack of saved words
	always @(posedge clk_sys_in or negedge nrst_in)
	begin
		if (!nrst_in)
		begin
			cnt <= 2'h0;
			instr_last_out <= 1'b0;
			return_from_irq_instr_out <= 1'b0;
			popped_out <= 8'h00;
			stack.delete();
		end
		else
		begin
			cnt <= cnt + 2'h1;
			instr_last_out <= (cnt == 2'h2);
			return_from_irq_instr_out <= ret_req_in;
			if (ack_in)
				stack.push_back(saved_status_in);
			if (ret_req_in && stack.size() > 0)
				popped_out <= stack.pop_back();
			else
				popped_out <= ~popped_out; // Not held outside a return
		end
	end
endmodule : cpu_core_model

// ==== bench/edge_select_key_return_irq_ack_tb_top.sv ====
`timescale 1ns/1ps
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin n_mismatch++; \
	$display("Error %0t: got %h want %h", $time, a, b); end end
module edge_select_key_return_irq_ack_tb_top;
	import irq_pkg::*;
	logic clk = 1'b0, nrst = 1'b0, wr = 1'b0, rd = 1'b0, ret = 1'b0;
	logic ei = 1'b0, di = 1'b0, ext = 1'b0, nm = 1'b0, last, return_from_irq_instr;
	logic sw = 1'b0, fa = 1'b0;
	logic [7:0] swd = 8'h00;
	logic [15:0] addr = 16'h0000;
	logic [7:0] wdata = 8'h00, src = 8'h00, rdata, program_status_word, saved, popped, d;
	logic [3:0] keys = 4'hf;
	logic ack, pend;
	ack_kind_type kind;
	logic [15:0] vec;
	int n_mismatch = 0, checked = 0, cyc = 0;
	// Clock and hang guard
	always #25 clk = ~clk;
	always @(posedge clk)
	begin
		cyc++;
		if (cyc > 20000)
		begin
			n_mismatch++;
			tally_and_finish();
		end
	end
	edge_select_key_return_irq_ack dut (.clk_sys_in(clk), .nrst_in(nrst),
		.addr_in(addr), .wdata_in(wdata), .wr_in(wr), .rd_in(rd),
		.rdata_out(rdata), .status_wr_in(sw), .status_wdata_in(swd),
		.enable_irq_instr_in(ei), .disable_irq_instr_in(di),
		.return_from_irq_instr_in(return_from_irq_instr), .popped_status_in(popped),
		.program_status_word_out(program_status_word), .instr_last_in(last),
		.flag_access_in(fa), .src_req_in(src), .ext_pin_irq_in(ext),
		.key_pins_in(keys), .nonmask_req_in(nm), .ack_out(ack),
		.ack_kind_out(kind), .vector_out(vec), .saved_status_out(saved),
		.pending_out(pend));
	cpu_core_model core (.clk_sys_in(clk), .nrst_in(nrst), .ack_in(ack),
		.saved_status_in(saved), .ret_req_in(ret), .instr_last_out(last),
		.return_from_irq_instr_out(return_from_irq_instr), .popped_out(popped));
	task automatic wr_reg(input logic [15:0] a, input logic [7:0] v);
		@(posedge clk) begin addr <= a; wdata <= v; wr <= 1'b1; end
		@(posedge clk) wr <= 1'b0;
	endtask : wr_reg
	task automatic rd_reg(input logic [15:0] a, output logic [7:0] v);
		@(posedge clk) begin addr <= a; rd <= 1'b1; end
		@(posedge clk) rd <= 1'b0;
		#1 v = rdata;
	endtask : rd_reg
	// Wait bounded for one acknowledge, then judge kind and vector
	task automatic expect_ack(input ack_kind_type k, input logic [15:0] v);
		int i;
		#1;
		for (i = 0; i < 40 && ack !== 1'b1; i++)
			@(posedge clk) #1;
		`CHK(ack, 1'b1)
		`CHK(kind, k)
		`CHK(vec, v)
		@(posedge clk) #1;
	endtask : expect_ack
	task automatic do_ret();
		@(posedge clk) ret <= 1'b1;
		@(posedge clk) ret <= 1'b0;
		repeat (2) @(posedge clk);
		#1;
	endtask : do_ret
	task automatic pulse_ei();
		@(posedge clk) ei <= 1'b1;
		@(posedge clk) ei <= 1'b0;
	endtask : pulse_ei
	task automatic reset_values();
		rd_reg(16'hffec, d); `CHK(d, 8'h00)
		rd_reg(16'hfff5, d); `CHK(d, 8'h00)
		rd_reg(16'h1234, d); `CHK(d, 8'h00)
		`CHK(program_status_word, 8'h02)
	endtask : reset_values
	// Pin source stays masked while its edge changes
	task automatic edge_codes();
		logic [1:0] c [4] = '{2'b00, 2'b01, 2'b11, 2'b10};
		foreach (c[i])
		begin
			wr_reg(16'hffec, {4'h0, c[i], 2'b00});
			wr_reg(16'hffe0, 8'h00);
			@(posedge clk) ext <= 1'b1;
			rd_reg(16'hffe0, d); `CHK(d[1], c[i][0])
			wr_reg(16'hffe0, 8'h00);
			@(posedge clk) ext <= 1'b0;
			rd_reg(16'hffe0, d); `CHK(d[1], c[i][1] == c[i][0])
		end
	endtask : edge_codes
	task automatic key_fall(input logic en, input logic [3:0] k, input logic e);
		wr_reg(16'hfff5, {7'h00, en});
		@(posedge clk) keys <= 4'hf;
		wr_reg(16'hffe0, 8'h00);
		@(posedge clk) keys <= k;
		rd_reg(16'hffe0, d); `CHK(d[6], e)
	endtask : key_fall
	// Acknowledge, flag clear, status save and restore
	task automatic single_ack();
		wr_reg(16'hffe0, 8'h00);
		wr_reg(16'hffe4, 8'hf7);
		pulse_ei();
		@(posedge clk) src <= 8'h08;
		@(posedge clk) src <= 8'h00;
		expect_ack(ACK_MASKABLE, 16'h000a);
		`CHK(program_status_word[7], 1'b0)
		`CHK(saved[7], 1'b1)
		rd_reg(16'hffe0, d); `CHK(d, 8'h00)
		do_ret(); `CHK(program_status_word[7], 1'b1)
	endtask : single_ack
	// Two at once: higher first, second waits for the return
	task automatic priority_pair();
		wr_reg(16'hffe4, 8'hdb);
		@(posedge clk) src <= 8'h24;
		@(posedge clk) src <= 8'h00;
		expect_ack(ACK_MASKABLE, 16'h0008);
		repeat (12)
		begin
			@(posedge clk) #1 `CHK(ack, 1'b0)
			`CHK(pend, 1'b1)
		end
		do_ret();
		expect_ack(ACK_MASKABLE, 16'h000e);
		do_ret();
	endtask : priority_pair
	// Byte write of the status word, then a flag access holding requests
	task automatic status_hold();
		@(posedge clk) begin swd <= 8'h02; sw <= 1'b1; end
		@(posedge clk) swd <= 8'h82;
		#1 `CHK(program_status_word, 8'h02)
		@(posedge clk) sw <= 1'b0;
		#1 `CHK(program_status_word, 8'h82)
		@(posedge clk) begin fa <= 1'b1; src <= 8'h04; end
		@(posedge clk) src <= 8'h00;
		repeat (12)
		begin
			@(posedge clk) #1 `CHK(ack, 1'b0)
		end
		@(posedge clk) fa <= 1'b0;
		expect_ack(ACK_MASKABLE, 16'h0008);
		do_ret();
	endtask : status_hold
	// Non-maskable beats maskable and nests into itself
	task automatic nonmask_nest();
		@(posedge clk) begin src <= 8'h04; nm <= 1'b1; end
		@(posedge clk) begin src <= 8'h00; nm <= 1'b0; end
		expect_ack(ACK_NONMASK, 16'h0004);
		@(posedge clk) nm <= 1'b1;
		@(posedge clk) nm <= 1'b0;
		expect_ack(ACK_NONMASK, 16'h0004);
		do_ret();
		do_ret();
		expect_ack(ACK_MASKABLE, 16'h0008);
		do_ret();
		@(posedge clk) di <= 1'b1;
		@(posedge clk) di <= 1'b0;
		#1 `CHK(program_status_word[7], 1'b0)
	endtask : nonmask_nest
	task automatic tally_and_finish();
		$display("Comparisons %0d, mismatches %0d", checked, n_mismatch);
		if (n_mismatch == 0 && checked > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : tally_and_finish
	// Main sequence
	initial
	begin
		repeat (10) @(posedge clk);
		nrst <= 1'b1;
		reset_values();
		edge_codes();
		key_fall(1'b1, 4'he, 1'b1);
		key_fall(1'b1, 4'hc, 1'b1);
		wr_reg(16'hffe0, 8'h00);
		@(posedge clk) keys <= 4'h8;
		rd_reg(16'hffe0, d); `CHK(d[6], 1'b0)
		key_fall(1'b0, 4'he, 1'b0);
		single_ack();
		priority_pair();
		status_hold();
		nonmask_nest();
		tally_and_finish();
	end
endmodule : edge_select_key_return_irq_ack_tb_top
